//--- rtl/can_rx_filter_routing_defs.svh
/*
  Offsets, field positions, reset values and codes for the receive filter
  control block. Assumes a 32-bit AHB-Lite bus with one register per word.
*/
// What this block does
// - One enable bit per filter gates matching
// - Reset enables filters 0-5 and 12
// - Length, pointers, mask selects: configuration-mode writes only
// - These registers absent in mode 0
// - Mode 0: length count reads zero
// - Length count 0..18 limits compared data bits
// - Zero data length compares no data
// - One byte: low three count bits, EID 7..0
// - Two bytes: low four count bits, EID 15..0
// - Three or more: five count bits, EID 17..0
// - Mask select: mask 0, mask 1, filter 15, none
// - Data length code four bits, 0..8 bytes
// - Filter extended enable restricts message type
`ifndef CAN_RX_FILTER_ROUTING_DEFS_SVH
`define CAN_RX_FILTER_ROUTING_DEFS_SVH

`define NUM_FILTERS      16
`define NUM_REGS         16
`define IDX_EN_LOW       4'h0
`define IDX_EN_HIGH      4'h1
`define IDX_DFL          4'h2
`define IDX_PTR0         4'h3
`define IDX_MASK_SELECT_FILTERS_0_3        4'hb
`define IDX_CTRL         4'hf
`define ADDR_IDX_MSB     5
`define ADDR_IDX_LSB     2
`define ADDR_SPAN_MSB    31
`define CTRL_MODE_LSB    0
`define CTRL_CONFIG_BIT  2
`define CTRL_WMASK       8'h07
`define DFL_WMASK        8'h1f
`define DFL_MAX          5'h12
`define DATA_BITS        18
`define DLC_ONE          4'h1
`define DLC_TWO          4'h2
`define DLC_BITS_ONE     5'h08
`define DLC_BITS_TWO     5'h10
`define PTR_LIMIT        4'h8
`define REG_RESET_ALL    128'h05_00_00_05_50_00_00_00_00_00_11_11_00_00_10_3f
`define MODE0_ENABLES    8'h3f
`define HTRANS_NONSEQ    2'h2
`define HTRANS_SEQ       2'h3

`endif

//--- rtl/can_rx_filter_pkg.sv
/*
  Types shared by the receive filter control block.
  Assumes the constants header is included by the user of each type.
*/
package can_rx_filter_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [28:0] can_id_t;
  typedef enum logic [1:0] {OP_MODE_0, OP_MODE_1, OP_MODE_2, OP_MODE_3} op_mode_t;
  typedef enum logic [1:0] {SEL_MASK_0, SEL_MASK_1, SEL_FILTER_15, SEL_NO_MASK} mask_sel_t;
endpackage : can_rx_filter_pkg

//--- rtl/can_rx_filter_routing.sv
/*
  Receive acceptance filter control: register file on AHB-Lite and the
  sixteen-way filter match with buffer routing. Assumes the protocol engine
  presents each received header as a one-cycle strobe on hclk, and that the
  filter and mask identifier registers live outside this block.
*/
`timescale 1ns/1ps
`include "can_rx_filter_routing_defs.svh"

module can_rx_filter_routing
  import can_rx_filter_pkg::*;
(
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire can_id_t [`NUM_FILTERS-1:0]   filter_id,
  input  wire logic [`NUM_FILTERS-1:0]      filter_ext_en,
  input  wire can_id_t [1:0]                mask_id,
  input  wire logic [1:0]                   mask_ext_en,
  input  wire logic                         rx_valid,
  input  wire can_id_t                      rx_id,
  input  wire logic                         rx_ext,
  input  wire logic [3:0]                   data_length_code,
  input  wire logic [`DATA_BITS-1:0]        rx_data_bits,
  output logic                              match_valid,
  output logic                              match_accept,
  output logic      [3:0]                   match_filter,
  output logic      [3:0]                   match_buffer,
  output logic      [1:0]                   op_mode,
  output logic                              config_mode
);

  reg_byte_t [`NUM_REGS-1:0]    regs;
  reg_byte_t [`NUM_REGS-1:0]    next_regs;
  reg_byte_t [`NUM_REGS-1:0]    eff;
  logic                         wr_pend;
  logic                         next_wr_pend;
  logic [3:0]                   wr_idx;
  logic [3:0]                   next_wr_idx;
  logic [31:0]                  next_hrdata;
  logic                         next_match_valid;
  logic                         next_match_accept;
  logic [3:0]                   next_match_filter;
  logic [3:0]                   next_match_buffer;
  logic                         filters_present;
  logic                         addr_ok;
  logic [3:0]                   rd_idx;
  logic [15:0]                  en_vec;
  logic [4:0]                   data_top;
  logic [4:0]                   data_cnt;
  logic [4:0]                   flc;
  logic [`DATA_BITS-1:0]        data_cmp;
  logic [`DATA_BITS-1:0]        data_care;
  logic [`NUM_FILTERS-1:0]      hit;
  logic [`NUM_FILTERS-1:0][3:0] ptr;
  logic                         wr_allowed;
  reg_byte_t                    wr_value;
  reg_byte_t                    rd_value;
  logic                         addr_mapped;

  // Modes 1 and 2 carry the extended filter registers
  assign filters_present = (regs[`IDX_CTRL][1:0] == OP_MODE_1) ||
                           (regs[`IDX_CTRL][1:0] == OP_MODE_2);
  assign addr_ok = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign rd_idx  = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

  // Effective settings: mode 0 falls back to the fixed legacy set
  always_comb begin
    eff = regs;
    if (!filters_present) begin
      eff = `REG_RESET_ALL;
      eff[`IDX_EN_LOW]  = `MODE0_ENABLES;
      eff[`IDX_EN_HIGH] = 8'h00;
      eff[`IDX_DFL]     = 8'h00;
      eff[`IDX_CTRL]    = regs[`IDX_CTRL];
    end
  end
  assign en_vec = {eff[`IDX_EN_HIGH], eff[`IDX_EN_LOW]};

  // Upper address bits must be clear; the rest of the space reads zero
  assign addr_mapped = (haddr[`ADDR_SPAN_MSB:`ADDR_IDX_MSB+1] == '0);

  // Which registers a landing write may touch in the current mode
  always_comb begin
    wr_allowed = 1'b0;
    case (wr_idx)
      `IDX_CTRL: begin
        wr_allowed = 1'b1;
      end
      `IDX_EN_LOW,
      `IDX_EN_HIGH: begin
        wr_allowed = filters_present;
      end
      default: begin
        // Routing is live while running, so it is locked outside configuration
        wr_allowed = filters_present && regs[`IDX_CTRL][`CTRL_CONFIG_BIT];
      end
    endcase
  end

  // Unimplemented bits are dropped on the way in
  always_comb begin
    case (wr_idx)
      `IDX_CTRL: begin
        wr_value = hwdata[7:0] & `CTRL_WMASK;
      end
      `IDX_DFL: begin
        wr_value = hwdata[7:0] & `DFL_WMASK;
      end
      default: begin
        wr_value = hwdata[7:0];
      end
    endcase
  end

  // Mode 0 hides everything but the control word
  always_comb begin
    rd_value = 8'h00;
    if (rd_idx == `IDX_CTRL || filters_present) begin
      rd_value = regs[rd_idx];
    end
  end

  // Register bus: address phase captured, write lands in the data phase
  always_comb begin
    next_regs    = regs;
    next_wr_pend = 1'b0;
    next_wr_idx  = wr_idx;
    next_hrdata  = hrdata;
    if (wr_pend && wr_allowed) begin
      next_regs[wr_idx] = wr_value;
    end
    if (addr_ok) begin
      next_wr_pend = hwrite && addr_mapped;
      next_wr_idx  = rd_idx;
      next_hrdata  = 32'h0000_0000;
      if (!hwrite && addr_mapped) begin
        next_hrdata = {24'h00_0000, rd_value};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs    <= `REG_RESET_ALL;
      wr_pend <= 1'b0;
      wr_idx  <= 4'h0;
    end else begin
      regs    <= next_regs;
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
    end
  end

  // Zero-wait slave: ready and response never change after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Data window and count from the received length
  always_comb begin
    flc      = eff[`IDX_DFL][4:0];
    data_top = 5'h00;
    data_cnt = 5'h00;
    case (data_length_code)
      4'h0: begin
        data_top = 5'h00;
        data_cnt = 5'h00;
      end
      `DLC_ONE: begin
        data_top = `DLC_BITS_ONE;
        data_cnt = {2'b00, flc[2:0]};
      end
      `DLC_TWO: begin
        data_top = `DLC_BITS_TWO;
        data_cnt = {1'b0, flc[3:0]};
      end
      default: begin
        // Reserved codes above 8 are taken as 8 bytes
        data_top = 5'(`DATA_BITS);
        data_cnt = (flc > `DFL_MAX) ? `DFL_MAX : flc;
      end
    endcase
    data_cmp = rx_data_bits >> (5'(`DATA_BITS) - data_top);
  end

  genvar g;

  // Care bits sit at the top of the window, first received bit highest
  generate
    for (g = 0; g < `DATA_BITS; g++) begin : g_care
      assign data_care[g] = (5'(g) < data_top) && (5'(g) >= data_top - data_cnt);
    end
  endgenerate

  generate
    for (g = 0; g < `NUM_FILTERS; g++) begin : g_filter
      mask_sel_t sel;
      can_id_t   m_id;
      logic      m_ext;
      logic      type_ok;
      logic      bits_ok;
      assign ptr[g] = eff[`IDX_PTR0 + g/2][4*(g%2) +: 4];
      assign sel    = mask_sel_t'(eff[`IDX_MASK_SELECT_FILTERS_0_3 + g/4][2*(g%4) +: 2]);
      always_comb begin
        case (sel)
          SEL_MASK_0: begin
            m_id  = mask_id[0];
            m_ext = mask_ext_en[0];
          end
          SEL_MASK_1: begin
            m_id  = mask_id[1];
            m_ext = mask_ext_en[1];
          end
          SEL_FILTER_15: begin
            m_id  = filter_id[15];
            m_ext = filter_ext_en[15];
          end
          default: begin
            m_id  = '1;
            m_ext = 1'b1;
          end
        endcase
      end
      assign type_ok = !m_ext || (filter_ext_en[g] == rx_ext);
      // Standard frames reuse the low extended bits for payload compare
      assign bits_ok = rx_ext ? (((rx_id ^ filter_id[g]) & m_id) == '0) :
                       ((({rx_id[10:0], data_cmp} ^ filter_id[g]) & m_id &
                         {11'h7ff, data_care}) == '0);
      // Reserved pointer codes have no buffer behind them
      assign hit[g] = en_vec[g] && type_ok && bits_ok &&
                      (ptr[g] < `PTR_LIMIT);
    end
  endgenerate

  // Lowest-numbered matching filter wins
  always_comb begin
    next_match_valid  = rx_valid;
    next_match_accept = 1'b0;
    next_match_filter = 4'h0;
    next_match_buffer = 4'h0;
    for (int i = `NUM_FILTERS - 1; i >= 0; i--) begin
      if (rx_valid && hit[i]) begin
        next_match_accept = 1'b1;
        next_match_filter = 4'(i);
        next_match_buffer = ptr[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_valid  <= 1'b0;
      match_accept <= 1'b0;
      match_filter <= 4'h0;
      match_buffer <= 4'h0;
    end else begin
      match_valid  <= next_match_valid;
      match_accept <= next_match_accept;
      match_filter <= next_match_filter;
      match_buffer <= next_match_buffer;
    end
  end

  // Mode outputs follow the control word as it is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_mode     <= 2'h0;
      config_mode <= 1'b0;
    end else begin
      op_mode     <= next_regs[`IDX_CTRL][1:0];
      config_mode <= next_regs[`IDX_CTRL][`CTRL_CONFIG_BIT];
    end
  end

endmodule : can_rx_filter_routing

//--- verif/can_rx_filter_routing_monitor.sv
/* Checker for the receive filter block: bus answers and the match strobe.
   Assumes it is bound to can_rx_filter_routing and sees only its ports. */
`timescale 1ns/1ps
module can_rx_filter_routing_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rx_valid,
  input wire logic        match_valid,
  input wire logic        match_accept,
  input wire logic [3:0]  match_buffer,
  input wire logic [1:0]  op_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken; hsel && hready && htrans[1] && !hwrite; endsequence
  a_ready_high: assert property (
    hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (
    !hresp) else $error("error response");
  a_match_follows: assert property (
    rx_valid |=> match_valid) else $error("no match strobe");
  a_no_spurious: assert property (
    !rx_valid |=> !match_valid) else $error("stray strobe");
  a_idle_quiet: assert property (
    !match_valid |-> !match_accept && match_buffer == 4'h0) else $error("idle accept");
  a_buffer_legal: assert property (
    match_accept |-> match_buffer < 4'h8) else $error("reserved pointer hit");
  a_mode0_zero: assert property (
    rd_taken ##0 (op_mode == 2'h0 && haddr[5:2] != 4'hf) |=> hrdata == 32'h0)
    else $error("mode 0 read not zero");
  a_length_width: assert property (
    rd_taken ##0 (haddr[5:2] == 4'h2) |=> hrdata[31:5] == 27'h0)
    else $error("length count too wide");
endmodule : can_rx_filter_routing_monitor

bind can_rx_filter_routing can_rx_filter_routing_monitor mon (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .rx_valid, .match_valid,
  .match_accept, .match_buffer, .op_mode);

//--- verif/can_rx_engine_model.sv
/* Protocol engine stand-in: turns a bench request into a one-cycle header strobe.
   Assumes the bench raises send for one hclk cycle per frame. */
`timescale 1ns/1ps
module can_rx_engine_model (
  input  wire logic        hclk,
  input  wire logic        send,
  input  wire logic [28:0] id_in,
  input  wire logic        ext_in,
  input  wire logic [3:0]  dlc_in,
  input  wire logic [17:0] data_in,
  output logic             rx_valid,
  output logic [28:0]      rx_id,
  output logic             rx_ext,
  output logic [3:0]       data_length_code,
  output logic [17:0]      rx_data_bits
);
  // Fields inverted between strobes so a stale header cannot pass as valid
  always_ff @(posedge hclk) begin
    rx_valid <= send;
    {rx_id, rx_ext, data_length_code, rx_data_bits} <= send ? {id_in, ext_in, dlc_in, data_in}
                                                            : ~{id_in, ext_in, dlc_in, data_in};
  end
endmodule : can_rx_engine_model

//--- verif/tb_top.sv
/* Bench for the receive filter block: registers over AHB-Lite, mode gating, matching.
   Assumes the engine model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module tb_top
  import can_rx_filter_pkg::*;
;
  logic           hclk, hresetn, hsel, hwrite, send, ext_in, rx_valid, rx_ext;
  logic           match_valid, match_accept, hreadyout, hresp, config_mode;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans, mask_ext_en, op_mode;
  logic [2:0]     hsize;
  logic [3:0]     dlc_in, data_length_code, match_filter, match_buffer;
  logic [17:0]    data_in, rx_data_bits;
  logic [15:0]    filter_ext_en, en;
  can_id_t        id_in, rx_id, sid, f;
  can_id_t [15:0] filter_id;
  can_id_t [1:0]  mask_id;
  int             bad_count, compares, j;
  logic [7:0]     rst_tab [16] = '{8'h3f, 8'h10, 8'h00, 8'h00, 8'h11, 8'h11, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h50, 8'h05, 8'h00, 8'h00, 8'h05};
  can_rx_filter_routing DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .filter_id, .filter_ext_en, .mask_id,
    .mask_ext_en, .rx_valid, .rx_id, .rx_ext, .data_length_code, .rx_data_bits, .match_valid,
    .match_accept, .match_filter, .match_buffer, .op_mode, .config_mode);
  can_rx_engine_model partner (.hclk, .send, .id_in, .ext_in, .dlc_in, .data_in, .rx_valid,
    .rx_id, .rx_ext, .data_length_code, .rx_data_bits);
  task print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wait_rdy();
    int n;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_rdy
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, a};
    wait_rdy();
    {htrans, hwdata} <= {2'h0, d};
    wait_rdy();
    r = hrdata;
  endtask : xfer
  // Buffer pointer left by reset for filter k
  function automatic logic [3:0] ptr_of(input int k);
    return (k >= 2 && k <= 5) ? 4'h1 : 4'h0;
  endfunction : ptr_of
  task frame(input can_id_t id, input logic ext, input logic [3:0] dlc, input logic [17:0] d,
             input logic acc, input logic [3:0] fil, input logic [3:0] bf);
    @(posedge hclk);
    {id_in, ext_in, dlc_in, data_in, send} <= {id, ext, dlc, d, 1'b1};
    @(posedge hclk);
    send <= 1'b0;
    @(posedge hclk);
    #1;
    chk("valid", 32'(match_valid), 32'h1);
    chk("accept", 32'(match_accept), 32'(acc));
    chk("filter", 32'(match_filter), acc ? 32'(fil) : 32'h0);
    chk("buffer", 32'(match_buffer), acc ? 32'(bf) : 32'h0);
  endtask : frame
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    void'($urandom(22));
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, send, ext_in, dlc_in, data_in, id_in} = '0;
    {hsize, mask_ext_en, mask_id, filter_ext_en} = {3'h2, 2'h3, {58{1'b1}}, 16'hffff};
    // Top bits carry the index so no two filters share an identifier
    for (int k = 0; k < 16; k++) filter_id[k] = {4'(k), 25'($urandom)};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 17; a++) begin
      xfer(1'b0, 32'(a * 4), 32'h0, rd);
      chk("reset value", rd, a < 16 ? 32'(rst_tab[a[3:0]]) : 32'h0);
    end
    en = 16'h103f;
    for (int i = 0; i < 12; i++) begin
      if (i > 0) begin
        en = 16'($urandom);
        xfer(1'b1, 32'h0, {24'h0, en[7:0]}, rd);
        xfer(1'b1, 32'h4, {24'h0, en[15:8]}, rd);
      end
      j = $urandom_range(15);
      frame(filter_id[j], 1'b1, 4'h8, 18'($urandom), en[j], 4'(j), ptr_of(j));
    end
    xfer(1'b1, 32'h0, 32'hff, rd);
    xfer(1'b1, 32'h4, 32'hff, rd);
    xfer(1'b1, 32'h8, 32'h12, rd);
    f = filter_id[1];
    sid = {18'h0, f[28:18]};
    frame(sid, 1'b0, 4'h0, 18'h0, 1'b0, 4'h0, 4'h0);
    filter_ext_en[1] <= 1'b0;
    frame(sid, 1'b0, 4'h0, ~f[17:0], 1'b1, 4'h1, 4'h0);
    frame(sid, 1'b0, 4'h1, {f[7:6], ~f[5:0], 10'h0}, 1'b1, 4'h1, 4'h0);
    frame(sid, 1'b0, 4'h1, {f[7], ~f[6], ~f[5:0], 10'h0}, 1'b0, 4'h0, 4'h0);
    xfer(1'b1, 32'h0, 32'h01, rd);
    xfer(1'b1, 32'h4, 32'h00, rd);
    {mask_id[1], mask_ext_en, filter_ext_en, filter_id[15]} <= {29'h0, 2'h1, 16'h7fff, 29'h0};
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 32'h2c, 32'(c), rd);
      frame(~filter_id[0], 1'b1, 4'h8, 18'h0, c == 1 || c == 2, 4'h0, 4'h0);
    end
    // Leave configuration mode, then drop to mode 0
    xfer(1'b1, 32'h3c, 32'h01, rd);
    #1;
    chk("op mode", 32'(op_mode), 32'h1);
    chk("config mode", 32'(config_mode), 32'h0);
    xfer(1'b1, 32'h8, 32'h05, rd);
    xfer(1'b0, 32'h8, 32'h0, rd);
    chk("length", rd, 32'h12);
    xfer(1'b1, 32'h3c, 32'h00, rd);
    #1;
    chk("op mode", 32'(op_mode), 32'h0);
    xfer(1'b0, 32'h8, 32'h0, rd);
    chk("length", rd, 32'h0);
    xfer(1'b0, 32'h0, 32'h0, rd);
    chk("enable", rd, 32'h0);
    // Reset in mid-run must bring back the power-on settings
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h3c, 32'h0, rd);
    chk("ctrl after reset", rd, 32'h05);
    chk("config after reset", 32'(config_mode), 32'h1);
    xfer(1'b0, 32'h0, 32'h0, rd);
    chk("enable after reset", rd, 32'h3f);
    print_verdict();
  end
endmodule : tb_top
